// >>> config_load_port.sv
// Configuration data entry port covering master serial, master parallel, peripheral and slave modes.
`timescale 1ns/100ps
`include "config_load_defines.svh"
// Functional notes
// - Byte captured when the write ends.
// - Busy shown within 60 ns of write end.
// - Busy lasts two to nine shift clock periods.
// - Next write accepted right when busy ends.
// - Shifting starts aligned to internal shift clock.
// - Read strobe high 600 ns, low 4 us.
// - Parallel data sampled late in read strobe.
// - Fetched parallel byte latched inside device.
// - Write only while all three selects and the strobe asserted.
// - Ready flag tells host when next byte accepted.
// - Shift clock driven in master/peripheral, received in slave.
module config_load_port (
  input  wire logic                        core_clk_i,
  input  wire logic                        nrst_i,
  input  wire logic [1:0]                  mode_pins_i,
  input  wire logic                        slave_clk_i,
  input  wire logic                        slave_data_i,
  input  wire logic                        serial_data_i,
  input  wire logic                        select_low_a_n_i,
  input  wire logic                        select_low_b_n_i,
  input  wire logic                        select_high_c_i,
  input  wire logic                        host_write_strobe_i,
  input  wire logic [`BYTE_W-1:0]          config_byte_bus_i,
  output logic                             config_shift_clock_o,
  output logic                             config_shift_clock_oe_o,
  output logic                             ready_busy_flag_o,
  output logic                             eprom_read_n_o,
  output logic [`ADDR_W-1:0]               eprom_addr_o,
  output logic [`BYTE_W-1:0]               cfg_byte_o,
  output logic                             cfg_byte_valid_o
);
  import config_load_pkg::*;

  localparam logic [`CNT_W-1:0] CONFIG_SHIFT_CLOCK_HALF = `CNT_W'(`CONFIG_SHIFT_CLOCK_HALF_CYC);
  localparam logic [`CNT_W-1:0] RD_HIGH   = `CNT_W'(`RD_HIGH_CYC);
  localparam logic [`CNT_W-1:0] RD_LOW    = `CNT_W'(`RD_LOW_CYC);

  logic [1:0]         mode_s1, mode_s2;
  logic [4:0]         pin_s1, pin_s2;
  logic [`BYTE_W-1:0] bus_s1, bus_s2, bus_d;
  cfg_mode_t          mode;
  logic               active;
  logic [`CNT_W-1:0]  config_shift_clock_cnt;
  logic               config_shift_clock_rise;
  logic               wr_act, wr_act_d, wr_end;
  periph_state_t      pstate;
  logic [`BYTE_W-1:0] hold_byte;
  logic [2:0]         pe_cnt;
  logic               pe_done;
  logic [`BYTE_W-1:0] ms_sh;
  logic [2:0]         ms_cnt;
  logic               ms_done;
  logic [`CNT_W-1:0]  rd_cnt;
  logic               mp_done;
  logic               lrst_s1, lrst_s2;
  logic [`BYTE_W-1:0] sl_sh, sl_byte;
  logic [2:0]         sl_cnt;
  logic               sl_tog, tog_s1, tog_s2, tog_s3;
  logic               sl_done;

  // Pins from outside this clock domain pass two flip-flops first; the mode pair keeps running through reset.
  // The third bus stage lines up with the last sample that still saw the write, so data need no hold.
  always_ff @(posedge core_clk_i) begin
    mode_s1 <= mode_pins_i;
    mode_s2 <= mode_s1;
    bus_d   <= bus_s2;
    if (!nrst_i) begin
      pin_s1  <= 5'h03;
      pin_s2  <= 5'h03;
      bus_s1  <= 8'h00;
      bus_s2  <= 8'h00;
    end else begin
      pin_s1  <= {serial_data_i, host_write_strobe_i, select_high_c_i, select_low_b_n_i, select_low_a_n_i};
      pin_s2  <= pin_s1;
      bus_s1  <= config_byte_bus_i;
      bus_s2  <= bus_s1;
    end
  end

  // Mode is latched once after reset release; holding reset low delays the start.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      mode   <= MODE_SLAVE;
      active <= 1'b0;
    end else if (!active) begin
      mode   <= cfg_mode_t'(mode_s2);
      active <= 1'b1;
    end
  end

  // Internal shift clock is divided from the core clock, starts high out of reset and then runs freely; only slave mode leaves the pin undriven.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      config_shift_clock_cnt                <= '0;
      config_shift_clock_o    <= 1'b1;
      config_shift_clock_oe_o <= 1'b0;
    end else begin
      config_shift_clock_oe_o <= active && (mode != MODE_SLAVE);
      if (config_shift_clock_cnt == CONFIG_SHIFT_CLOCK_HALF - 1'b1) begin
        config_shift_clock_cnt             <= '0;
        config_shift_clock_o <= !config_shift_clock_o;
      end else begin
        config_shift_clock_cnt <= config_shift_clock_cnt + 1'b1;
      end
    end
  end
  assign config_shift_clock_rise = (config_shift_clock_cnt == CONFIG_SHIFT_CLOCK_HALF - 1'b1) && !config_shift_clock_o;

  // A write is the joint assertion of all three selects and the strobe; its end loads the byte.
  assign wr_act = !pin_s2[0] && !pin_s2[1] && pin_s2[2] && pin_s2[3];
  assign wr_end = wr_act_d && !wr_act && active && (mode == MODE_PERIPH);

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      wr_act_d <= 1'b0;
    end else begin
      wr_act_d <= wr_act;
    end
  end

  // Peripheral byte handling; the byte is held so the host may drop data at the strobe edge.
  // Busy spans the wait for the shift clock phase plus eight shift periods, so it stays within nine.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      pstate            <= P_IDLE;
      hold_byte         <= 8'h00;
      pe_cnt            <= 3'h0;
      ready_busy_flag_o <= 1'b1;
    end else begin
      case (pstate)
        P_IDLE: begin
          ready_busy_flag_o <= 1'b1;
          if (wr_end) begin
            hold_byte         <= bus_d;
            ready_busy_flag_o <= 1'b0;
            pstate            <= P_HELD;
          end
        end
        P_HELD: begin
          if (config_shift_clock_rise) begin
            pe_cnt <= 3'h0;
            pstate <= P_SHIFT;
          end
        end
        P_SHIFT: begin
          if (config_shift_clock_rise) begin
            pe_cnt <= pe_cnt + 1'b1;
            if (pe_cnt == `BIT_LAST) begin
              ready_busy_flag_o <= 1'b1;
              pstate            <= P_IDLE;
            end
          end
        end
        default: pstate <= P_IDLE;
      endcase
    end
  end
  assign pe_done = (pstate == P_SHIFT) && config_shift_clock_rise && (pe_cnt == `BIT_LAST);

  // Master serial: a bit is taken at each rising edge of the driven shift clock, first bit ends up on top.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      ms_sh  <= 8'h00;
      ms_cnt <= 3'h0;
    end else if (active && (mode == MODE_MSERIAL) && config_shift_clock_rise) begin
      ms_sh  <= {ms_sh[`BYTE_W-2:0], pin_s2[4]};
      ms_cnt <= ms_cnt + 1'b1;
    end
  end
  assign ms_done = active && (mode == MODE_MSERIAL) && config_shift_clock_rise && (ms_cnt == `BIT_LAST);

  // Master parallel: data is sampled at the very end of the long low phase, so slow memories work.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rd_cnt         <= '0;
      eprom_read_n_o <= 1'b1;
      eprom_addr_o   <= '0;
    end else if (active && (mode == MODE_MPARALLEL)) begin
      if (eprom_read_n_o && (rd_cnt == RD_HIGH - 1'b1)) begin
        rd_cnt         <= '0;
        eprom_read_n_o <= 1'b0;
      end else if (!eprom_read_n_o && (rd_cnt == RD_LOW - 1'b1)) begin
        rd_cnt         <= '0;
        eprom_read_n_o <= 1'b1;
        eprom_addr_o   <= eprom_addr_o + 1'b1;
      end else begin
        rd_cnt <= rd_cnt + 1'b1;
      end
    end
  end
  assign mp_done = active && (mode == MODE_MPARALLEL) && !eprom_read_n_o && (rd_cnt == RD_LOW - 1'b1);

  // Link domain reset is a synchronised copy taken on the external clock, so it only follows nrst_i while that clock runs.
  always_ff @(posedge slave_clk_i) begin
    lrst_s1 <= nrst_i;
    lrst_s2 <= lrst_s1;
  end

  // Slave shifting on the external clock; a finished byte is parked and announced by a toggle.
  always_ff @(posedge slave_clk_i) begin
    if (!lrst_s2) begin
      sl_sh   <= 8'h00;
      sl_cnt  <= 3'h0;
      sl_byte <= 8'h00;
      sl_tog  <= 1'b0;
    end else begin
      sl_sh  <= {sl_sh[`BYTE_W-2:0], slave_data_i};
      sl_cnt <= sl_cnt + 1'b1;
      if (sl_cnt == `BIT_LAST) begin
        sl_byte <= {sl_sh[`BYTE_W-2:0], slave_data_i};
        sl_tog  <= !sl_tog;
      end
    end
  end

  // Toggle crossing; the parked byte is stable for eight link clocks, far longer than the sync delay.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end else begin
      tog_s1 <= sl_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end
  assign sl_done = (tog_s2 != tog_s3) && active && (mode == MODE_SLAVE);

  // One registered byte stream out, whichever mode produced it.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cfg_byte_o       <= 8'h00;
      cfg_byte_valid_o <= 1'b0;
    end else begin
      cfg_byte_valid_o <= pe_done || ms_done || mp_done || sl_done;
      if (pe_done) begin
        cfg_byte_o <= hold_byte;
      end else if (ms_done) begin
        cfg_byte_o <= {ms_sh[`BYTE_W-2:0], pin_s2[4]};
      end else if (mp_done) begin
        cfg_byte_o <= bus_s2;
      end else if (sl_done) begin
        cfg_byte_o <= sl_byte;
      end
    end
  end

  // Checking helpers: cycle counts of the busy and read strobe phases.
  logic [11:0] busy_len, rd_len;
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      busy_len <= 12'h000;
      rd_len   <= 12'h000;
    end else begin
      busy_len <= ready_busy_flag_o ? 12'h000 : busy_len + 1'b1;
      rd_len   <= (eprom_read_n_o != $past(eprom_read_n_o)) ? 12'h001 : rd_len + 1'b1;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  busy_fast_a: assert property (wr_end |=> !ready_busy_flag_o) else $error("busy late");
  busy_len_a: assert property ($rose(ready_busy_flag_o) |-> (busy_len >= 12'(4 * `CONFIG_SHIFT_CLOCK_HALF_CYC))
    && (busy_len <= 12'(18 * `CONFIG_SHIFT_CLOCK_HALF_CYC))) else $error("busy length off");
  byte_hold_a: assert property (wr_end |=> hold_byte == $past(bus_d)) else $error("byte not captured");
  next_write_a: assert property ($rose(ready_busy_flag_o) ##[1:40] wr_end |=> !ready_busy_flag_o)
    else $error("write after busy lost");
  idle_ready_a: assert property (pstate == P_IDLE && !$past(wr_end) |-> ready_busy_flag_o)
    else $error("idle not ready");
  shift_align_a: assert property ($rose(pstate == P_SHIFT) |-> $past(config_shift_clock_rise)) else $error("unaligned start");
  rd_high_a: assert property ($fell(eprom_read_n_o) |-> rd_len >= 12'(`RD_HIGH_CYC))
    else $error("read strobe high short");
  rd_low_a: assert property ($rose(eprom_read_n_o) |-> rd_len >= 12'(`RD_LOW_CYC))
    else $error("read strobe low short");
  late_sample_a: assert property ($rose(eprom_read_n_o) |-> cfg_byte_valid_o && cfg_byte_o == $past(bus_s2))
    else $error("parallel byte wrong");
  clk_drive_a: assert property (active && $stable(mode) ##1 1'b1 |-> config_shift_clock_oe_o == (mode != MODE_SLAVE))
    else $error("shift clock drive wrong");
  write_only_a: assert property ($fell(ready_busy_flag_o) |-> $past(wr_act_d)) else $error("busy without write");

  periph_byte_c: cover property (pe_done);
  serial_byte_c: cover property (ms_done);
  parallel_byte_c: cover property (mp_done);
  slave_byte_c: cover property (sl_done);
endmodule

// >>> config_load_defines.svh
// Timing counts and field constants for the configuration loader.
`ifndef CONFIG_LOAD_DEFINES_SVH
`define CONFIG_LOAD_DEFINES_SVH
`define CORE_PERIOD_NS    4
`define CONFIG_SHIFT_CLOCK_HALF_NS      500
`define CONFIG_SHIFT_CLOCK_HALF_CYC     ((`CONFIG_SHIFT_CLOCK_HALF_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`define RD_HIGH_NS        600
`define RD_HIGH_CYC       ((`RD_HIGH_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`define RD_LOW_NS         4000
`define RD_LOW_CYC        ((`RD_LOW_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`define CNT_W             11
`define BYTE_W            8
`define ADDR_W            16
`define BIT_LAST          3'h7
`endif

// >>> config_load_pkg.sv
// Types shared by the configuration loader.
package config_load_pkg;
  typedef enum logic [1:0] {MODE_MSERIAL, MODE_MPARALLEL, MODE_PERIPH, MODE_SLAVE} cfg_mode_t;
  typedef enum logic [1:0] {P_IDLE, P_HELD, P_SHIFT} periph_state_t;
endpackage

// >>> far_side_model.sv
// Far-side model of the serial memory and the parallel EPROM that feed the loader.
`timescale 1ns/100ps
module far_side_model (
  input  wire logic        nrst_i,
  input  wire logic        shift_clk_i,
  input  wire logic        read_n_i,
  input  wire logic [15:0] addr_i,
  output logic             serial_bit_o,
  output logic [7:0]       eprom_data_o
);
  localparam logic [7:0] SER_BYTE = 8'hc6;
  logic [2:0] idx = 3'h0;
  // The serial memory offers its next bit after each shift clock rise, most significant bit first.
  always @(posedge shift_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      idx <= 3'h0;
    else
      idx <= idx + 3'h1;
  end
  assign serial_bit_o = SER_BYTE[3'h7 - idx];
  initial eprom_data_o = 8'h00;
  // A slow memory: data turns valid late in the low phase, so a loader that samples early reads garbage.
  always @(negedge read_n_i) begin
    eprom_data_o <= ~eprom_data_o;
    #3800 eprom_data_o <= addr_i[7:0] ^ 8'ha5;
  end
  // Outputs are withdrawn as the strobe rises; no hold is offered.
  always @(posedge read_n_i) eprom_data_o <= ~eprom_data_o;
endmodule

// >>> test_config_load_port_timing.sv
// Self-checking bench for the configuration loader in all four modes.
`timescale 1ns/100ps
module test_config_load_port_timing;
  import config_load_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, slv_clk = 1'b1, slv_dat = 1'b0;
  logic sel_a_n = 1'b1, sel_b_n = 1'b1, sel_c = 1'b0, strobe = 1'b0;
  logic [7:0] host_bus = 8'h00, ep_data, byte_q;
  logic [15:0] addr;
  logic ser_bit, sclk, sclk_oe, ready, read_n, valid;
  cfg_mode_t mode = MODE_PERIPH;
  int bad_count = 0, num_checks = 0, cycles = 0;
  always #2 clk = ~clk;
  config_load_port config_load_port_i (.core_clk_i(clk), .nrst_i(nrst), .mode_pins_i(mode),
    .slave_clk_i(slv_clk), .slave_data_i(slv_dat), .serial_data_i(ser_bit), .select_low_a_n_i(sel_a_n),
    .select_low_b_n_i(sel_b_n), .select_high_c_i(sel_c), .host_write_strobe_i(strobe),
    .config_byte_bus_i(mode == MODE_MPARALLEL ? ep_data : host_bus), .config_shift_clock_o(sclk),
    .config_shift_clock_oe_o(sclk_oe), .ready_busy_flag_o(ready), .eprom_read_n_o(read_n),
    .eprom_addr_o(addr), .cfg_byte_o(byte_q), .cfg_byte_valid_o(valid));
  far_side_model far_side_model_i (.nrst_i(nrst), .shift_clk_i(sclk), .read_n_i(read_n),
    .addr_i(addr), .serial_bit_o(ser_bit), .eprom_data_o(ep_data));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Link clock bursts at 12 ns and parks High between frames; low phase far below 5 us.
  task automatic send_link(input logic [7:0] b);
    #1.3;
    for (int i = 7; i >= 0; i--) begin
      slv_clk = 1'b0;
      slv_dat = b[i];
      #6 slv_clk = 1'b1;
      #6;
    end
    slv_dat = ~b[0];
  endtask
  // Reset low is the hold-off; configuration starts only after release, as chained devices are ready.
  task automatic do_reset(input cfg_mode_t m);
    @(negedge clk);
    nrst = 1'b0;
    mode = m;
    send_link(8'h00);
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    // Two link edges after release let the link-side reset copy clear before the first frame.
    repeat (2) begin
      #6 slv_clk = 1'b0;
      #6 slv_clk = 1'b1;
    end
    repeat (4) @(negedge clk);
  endtask
  task automatic host_write(input logic [7:0] b, input logic c);
    host_bus = b;
    sel_a_n = 1'b0;
    sel_b_n = 1'b0;
    sel_c = c;
    strobe = 1'b1;
    repeat (26) @(negedge clk);
    // Data flips with the strobe edge, so the loader must keep the byte seen before the write ended.
    strobe = 1'b0;
    sel_a_n = 1'b1;
    sel_b_n = 1'b1;
    sel_c = 1'b0;
    host_bus = ~b;
  endtask
  task automatic wait_lvl(input logic lvl, input int lim, output int n);
    n = 0;
    while (ready !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic test_periph();
    int n;
    do_reset(MODE_PERIPH);
    host_write(8'h5a, 1'b0);
    repeat (30) @(negedge clk);
    check(ready, 1'b1);
    for (int k = 0; k < 3; k++) begin
      host_write(8'h81 + 8'(k * 37), 1'b1);
      wait_lvl(1'b0, 13, n);
      check(n < 13, 1'b1);
      wait_lvl(1'b1, 2400, n);
      check(n >= 500 && n <= 2250, 1'b1);
      check(valid, 1'b1);
      check(byte_q, 8'h81 + 8'(k * 37));
    end
    $display("peripheral test done");
  endtask
  task automatic test_mparallel();
    int n;
    logic [15:0] a;
    do_reset(MODE_MPARALLEL);
    for (int i = 0; i < 2; i++) begin
      n = 0;
      while (read_n !== 1'b0 && n < 400) begin @(negedge clk); n++; end
      if (i > 0) check(n >= 150, 1'b1);
      a = addr;
      n = 0;
      while (read_n === 1'b0 && n < 1100) begin @(negedge clk); n++; end
      check(n >= 1000, 1'b1);
      check(valid, 1'b1);
      check(byte_q, a[7:0] ^ 8'ha5);
      check(addr, a + 16'h0001);
    end
    $display("master parallel test done");
  endtask
  task automatic test_mserial();
    int n = 0;
    do_reset(MODE_MSERIAL);
    check(sclk_oe, 1'b1);
    check(sclk, 1'b1);
    while (valid !== 1'b1 && n < 2700) begin @(negedge clk); n++; end
    check(valid, 1'b1);
    check(byte_q, 8'hc6);
    $display("master serial test done");
  endtask
  task automatic test_slave();
    int n;
    do_reset(MODE_SLAVE);
    check(sclk_oe, 1'b0);
    for (int k = 0; k < 2; k++) begin
      send_link(k ? 8'hd2 : 8'h3c);
      n = 0;
      while (valid !== 1'b1 && n < 10) begin @(negedge clk); n++; end
      check(valid, 1'b1);
      check(byte_q, k ? 8'hd2 : 8'h3c);
    end
    $display("slave test done");
  endtask
  // Hang guard sized well above the longest expected run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    test_periph();
    test_mparallel();
    test_mserial();
    test_slave();
    tally_and_finish();
  end
endmodule
